/* File: hdl/cmb_pkg.sv */
package cmb_pkg;

	// Buffer geometry in words
	localparam int WORDS_PER_BUF  = 8;
	localparam int WORD_SEL_W     = 3;
	localparam int WORD_W         = 16;

	// Word indices inside one buffer
	localparam logic [2:0] W_STD_ID    = 3'h0;
	localparam logic [2:0] W_EXT_HIGH  = 3'h1;
	localparam logic [2:0] W_EXT_LOW   = 3'h2;
	localparam logic [2:0] W_PAYLOAD_0 = 3'h3;
	localparam logic [2:0] W_PAYLOAD_1 = 3'h4;
	localparam logic [2:0] W_PAYLOAD_2 = 3'h5;
	localparam logic [2:0] W_PAYLOAD_3 = 3'h6;
	localparam logic [2:0] W_FILTER    = 3'h7;

	// Last word read back for a transmit buffer
	localparam logic [2:0] W_TX_LAST   = 3'h6;

	// Word 0 fields
	localparam int STD_ID_LSB  = 2;
	localparam int STD_ID_MSB  = 12;
	localparam int SRR_BIT     = 1;
	localparam int IDE_BIT     = 0;

	// Word 1 fields: extension bits 17..6
	localparam int EXT_HI_MSB  = 11;
	localparam int EXT_HI_LSB  = 0;

	// Word 2 fields
	localparam int EXT_LO_MSB  = 15;
	localparam int EXT_LO_LSB  = 10;
	localparam int RTR_BIT     = 9;
	localparam int RSV_HI_BIT  = 8;
	localparam int RSV_LO_BIT  = 4;
	localparam int DLC_MSB     = 3;
	localparam int DLC_LSB     = 0;

	// Word 7 fields
	localparam int FILT_MSB    = 12;
	localparam int FILT_LSB    = 8;

	// Field widths
	localparam int BASE_ID_W   = 11;
	localparam int EXT_ID_W    = 18;
	localparam int DLC_W       = 4;
	localparam int FILT_W      = 5;
	localparam int PAYLOAD_W   = 64;

	// Flag reset value
	localparam logic FLAG_RST  = 1'b0;

	// Engine states
	typedef enum logic [2:0] {
		CMB_IDLE,
		CMB_CHECK,
		CMB_RX_WR,
		CMB_TX_RD
	} cmb_state_t;

endpackage

/* File: hdl/cmb_word_pack.sv */
`timescale 1ns/1ps

// Builds one buffer word from the message fields
module cmb_word_pack
	import cmb_pkg::*;
(
	// Word select
	input  wire logic [WORD_SEL_W-1:0] word_sel_in,
	// Message fields
	input  wire logic [BASE_ID_W-1:0]  base_identifier_in,
	input  wire logic                  srr_in,
	input  wire logic                  ide_in,
	input  wire logic [EXT_ID_W-1:0]   identifier_extension_in,
	input  wire logic                  rtr_in,
	input  wire logic [DLC_W-1:0]      dlc_in,
	input  wire logic [PAYLOAD_W-1:0]  payload_in,
	input  wire logic [FILT_W-1:0]     matching_filter_code_in,
	// Packed word
	output logic      [WORD_W-1:0]     word_out
);

	// Unused and reserved positions stay zero
	always_comb begin
		word_out = 16'h0000;
		case (word_sel_in)
			W_STD_ID: begin
				word_out[STD_ID_MSB:STD_ID_LSB] = base_identifier_in;
				word_out[SRR_BIT]               = srr_in;
				word_out[IDE_BIT]               = ide_in;
			end
			W_EXT_HIGH: begin
				word_out[EXT_HI_MSB:EXT_HI_LSB] = identifier_extension_in[17:6];
			end
			W_EXT_LOW: begin
				word_out[EXT_LO_MSB:EXT_LO_LSB] = identifier_extension_in[5:0];
				word_out[RTR_BIT]               = rtr_in;
				word_out[DLC_MSB:DLC_LSB]       = dlc_in;
			end
			W_PAYLOAD_0: word_out = {payload_in[15:8], payload_in[7:0]};
			W_PAYLOAD_1: word_out = {payload_in[31:24], payload_in[23:16]};
			W_PAYLOAD_2: word_out = {payload_in[47:40], payload_in[39:32]};
			W_PAYLOAD_3: word_out = {payload_in[63:56], payload_in[55:48]};
			W_FILTER: begin
				word_out[FILT_MSB:FILT_LSB] = matching_filter_code_in;
			end
			default: word_out = 16'h0000;
		endcase
	end

endmodule

/* File: hdl/cmb_msg_buffer_engine.sv */
`timescale 1ns/1ps

module cmb_msg_buffer_engine
	import cmb_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int NBUF   = 32
) (
	// Clock and reset
	input  wire logic                   clock_in,
	input  wire logic                   rst_in,
	// Region set by software
	input  wire logic [ADDR_W-1:0]      region_base_in,
	input  wire logic [5:0]             region_bufs_in,
	// Received message from the protocol controller
	input  wire logic                   rx_valid_in,
	output logic                        rx_ready_out,
	input  wire logic [4:0]             rx_buf_idx_in,
	input  wire logic [BASE_ID_W-1:0]   rx_base_identifier_in,
	input  wire logic                   rx_srr_in,
	input  wire logic                   rx_ide_in,
	input  wire logic [EXT_ID_W-1:0]    rx_identifier_extension_in,
	input  wire logic                   rx_rtr_in,
	input  wire logic [DLC_W-1:0]       rx_dlc_in,
	input  wire logic [PAYLOAD_W-1:0]   rx_payload_in,
	input  wire logic [FILT_W-1:0]      rx_matching_filter_code_in,
	output logic                        rx_stored_out,
	output logic                        rx_dropped_out,
	output logic                        rx_range_err_out,
	// Transmit buffer fetch
	input  wire logic                   tx_req_in,
	output logic                        tx_ready_out,
	input  wire logic [4:0]             tx_buf_idx_in,
	output logic                        tx_done_out,
	output logic                        tx_range_err_out,
	output logic [BASE_ID_W-1:0]        tx_base_identifier_out,
	output logic                        tx_srr_out,
	output logic                        tx_ide_out,
	output logic [EXT_ID_W-1:0]         tx_identifier_extension_out,
	output logic                        tx_rtr_out,
	output logic [DLC_W-1:0]            tx_dlc_out,
	output logic [PAYLOAD_W-1:0]        tx_payload_out,
	// Flag access from software
	input  wire logic                   full_wr_in,
	input  wire logic [NBUF-1:0]        full_wdata_in,
	input  wire logic                   ovf_wr_in,
	input  wire logic [NBUF-1:0]        ovf_wdata_in,
	output logic [NBUF-1:0]             rx_buffer_full_flag_out,
	output logic [NBUF-1:0]             rx_buffer_overflow_flag_out,
	// DMA memory port
	output logic                        ram_req_out,
	output logic                        ram_we_out,
	output logic [ADDR_W-1:0]           ram_addr_out,
	output logic [WORD_W-1:0]           ram_wdata_out,
	input  wire logic                   ram_ack_in,
	input  wire logic [WORD_W-1:0]      ram_rdata_in
);

	// Elaboration checks
	if (NBUF < 1 || NBUF > 32) begin : g_bad_nbuf
		$error("NBUF must lie in 1..32");
	end
	if (ADDR_W < 8) begin : g_bad_addr
		$error("ADDR_W must be at least 8");
	end

	// Engine state and latched message
	cmb_state_t               state_q;
	logic                     is_tx_q;
	logic [4:0]               buf_q;
	logic [WORD_SEL_W-1:0]    word_q;
	logic [BASE_ID_W-1:0]     m_base_id_q;
	logic                     m_srr_q;
	logic                     m_ide_q;
	logic [EXT_ID_W-1:0]      m_ext_id_q;
	logic                     m_rtr_q;
	logic [DLC_W-1:0]         m_dlc_q;
	logic [PAYLOAD_W-1:0]     m_payload_q;
	logic [FILT_W-1:0]        m_filt_q;
	logic [NBUF-1:0]          full_q;
	logic [NBUF-1:0]          ovf_q;
	logic [WORD_W-1:0]        packed_word;
	logic                     buf_in_region;
	logic                     buf_is_full;
	logic                     last_rx_ack;
	logic [NBUF-1:0]          full_set;
	logic [NBUF-1:0]          ovf_set;
	logic [ADDR_W-1:0]        word_addr;

	// Region check and address relative to software base
	assign buf_in_region = ({1'b0, buf_q} < region_bufs_in) && (32'(buf_q) < NBUF);
	assign buf_is_full   = full_q[buf_q[$clog2(NBUF > 1 ? NBUF : 2)-1:0]];
	assign word_addr     = region_base_in + ADDR_W'({buf_q, word_q});
	assign last_rx_ack   = (state_q == CMB_RX_WR) && ram_req_out && ram_ack_in && (word_q == W_FILTER);

	// One-hot flag set vectors
	always_comb begin
		full_set = '0;
		ovf_set  = '0;
		if (last_rx_ack) begin
			full_set[buf_q[$clog2(NBUF > 1 ? NBUF : 2)-1:0]] = 1'b1;
		end
		if ((state_q == CMB_CHECK) && !is_tx_q && buf_in_region && buf_is_full) begin
			ovf_set[buf_q[$clog2(NBUF > 1 ? NBUF : 2)-1:0]] = 1'b1;
		end
	end

	// Word builder for received messages
	cmb_word_pack u_pack (
		.word_sel_in             (word_q),
		.base_identifier_in      (m_base_id_q),
		.srr_in                  (m_srr_q),
		.ide_in                  (m_ide_q),
		.identifier_extension_in (m_ext_id_q),
		.rtr_in                  (m_rtr_q),
		.dlc_in                  (m_dlc_q),
		.payload_in              (m_payload_q),
		.matching_filter_code_in (m_filt_q),
		.word_out                (packed_word)
	);

	// Sequencer: accept, check, walk the words
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_q      <= CMB_IDLE;
			is_tx_q      <= 1'b0;
			buf_q        <= 5'h00;
			word_q       <= 3'h0;
			rx_ready_out <= 1'b1;
			tx_ready_out <= 1'b1;
		end else begin
			case (state_q)
				CMB_IDLE: begin
					word_q <= 3'h0;
					if (rx_valid_in) begin
						state_q      <= CMB_CHECK;
						is_tx_q      <= 1'b0;
						buf_q        <= rx_buf_idx_in;
						rx_ready_out <= 1'b0;
						tx_ready_out <= 1'b0;
					end else if (tx_req_in) begin
						state_q      <= CMB_CHECK;
						is_tx_q      <= 1'b1;
						buf_q        <= tx_buf_idx_in;
						rx_ready_out <= 1'b0;
						tx_ready_out <= 1'b0;
					end
				end
				CMB_CHECK: begin
					if (!buf_in_region || (!is_tx_q && buf_is_full)) begin
						state_q      <= CMB_IDLE;
						rx_ready_out <= 1'b1;
						tx_ready_out <= 1'b1;
					end else if (is_tx_q) begin
						state_q <= CMB_TX_RD;
					end else begin
						state_q <= CMB_RX_WR;
					end
				end
				CMB_RX_WR, CMB_TX_RD: begin
					if (ram_req_out && ram_ack_in) begin
						if ((state_q == CMB_RX_WR && word_q == W_FILTER) ||
						    (state_q == CMB_TX_RD && word_q == W_TX_LAST)) begin
							state_q      <= CMB_IDLE;
							rx_ready_out <= 1'b1;
							tx_ready_out <= 1'b1;
						end else begin
							word_q <= word_q + 3'h1;
						end
					end
				end
				default: begin
					state_q      <= CMB_IDLE;
					rx_ready_out <= 1'b1;
					tx_ready_out <= 1'b1;
				end
			endcase
		end
	end

	// Latch received message on acceptance
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			m_base_id_q <= '0;
			m_srr_q     <= 1'b0;
			m_ide_q     <= 1'b0;
			m_ext_id_q  <= '0;
			m_rtr_q     <= 1'b0;
			m_dlc_q     <= '0;
			m_payload_q <= '0;
			m_filt_q    <= '0;
		end else if (state_q == CMB_IDLE && rx_valid_in) begin
			m_base_id_q <= rx_base_identifier_in;
			m_srr_q     <= rx_srr_in;
			m_ide_q     <= rx_ide_in;
			m_ext_id_q  <= rx_identifier_extension_in;
			m_rtr_q     <= rx_rtr_in;
			m_dlc_q     <= rx_dlc_in;
			m_payload_q <= rx_payload_in;
			m_filt_q    <= rx_matching_filter_code_in;
		end
	end

	// Memory port: one word per request, held until acknowledged
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ram_req_out   <= 1'b0;
			ram_we_out    <= 1'b0;
			ram_addr_out  <= '0;
			ram_wdata_out <= 16'h0000;
		end else if (state_q == CMB_RX_WR || state_q == CMB_TX_RD) begin
			if (!ram_req_out) begin
				ram_req_out   <= 1'b1;
				ram_we_out    <= (state_q == CMB_RX_WR);
				ram_addr_out  <= word_addr;
				ram_wdata_out <= (state_q == CMB_RX_WR) ? packed_word : 16'h0000;
			end else if (ram_ack_in) begin
				ram_req_out <= 1'b0;
				ram_we_out  <= 1'b0;
			end
		end else begin
			ram_req_out <= 1'b0;
			ram_we_out  <= 1'b0;
		end
	end

	// Unpack transmit words as they return; filter word is never read
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tx_base_identifier_out      <= '0;
			tx_srr_out                  <= 1'b0;
			tx_ide_out                  <= 1'b0;
			tx_identifier_extension_out <= '0;
			tx_rtr_out                  <= 1'b0;
			tx_dlc_out                  <= '0;
			tx_payload_out              <= '0;
		end else if (state_q == CMB_TX_RD && ram_req_out && ram_ack_in) begin
			case (word_q)
				W_STD_ID: begin
					tx_base_identifier_out <= ram_rdata_in[STD_ID_MSB:STD_ID_LSB];
					tx_srr_out             <= ram_rdata_in[SRR_BIT];
					tx_ide_out             <= ram_rdata_in[IDE_BIT];
				end
				W_EXT_HIGH: begin
					tx_identifier_extension_out[17:6] <= ram_rdata_in[EXT_HI_MSB:EXT_HI_LSB];
				end
				W_EXT_LOW: begin
					tx_identifier_extension_out[5:0] <= ram_rdata_in[EXT_LO_MSB:EXT_LO_LSB];
					tx_rtr_out                       <= ram_rdata_in[RTR_BIT];
					tx_dlc_out                       <= ram_rdata_in[DLC_MSB:DLC_LSB];
				end
				W_PAYLOAD_0: tx_payload_out[15:0]  <= ram_rdata_in;
				W_PAYLOAD_1: tx_payload_out[31:16] <= ram_rdata_in;
				W_PAYLOAD_2: tx_payload_out[47:32] <= ram_rdata_in;
				W_PAYLOAD_3: tx_payload_out[63:48] <= ram_rdata_in;
				default: begin
				end
			endcase
		end
	end

	// Completion and error pulses
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rx_stored_out    <= 1'b0;
			rx_dropped_out   <= 1'b0;
			rx_range_err_out <= 1'b0;
			tx_done_out      <= 1'b0;
			tx_range_err_out <= 1'b0;
		end else begin
			rx_stored_out    <= last_rx_ack;
			rx_dropped_out   <= |ovf_set;
			rx_range_err_out <= (state_q == CMB_CHECK) && !is_tx_q && !buf_in_region;
			tx_range_err_out <= (state_q == CMB_CHECK) && is_tx_q && !buf_in_region;
			tx_done_out      <= (state_q == CMB_TX_RD) && ram_req_out && ram_ack_in && (word_q == W_TX_LAST);
		end
	end

	// Full flags: set wins over a software clear in the same cycle
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			full_q <= {NBUF{FLAG_RST}};
		end else begin
			full_q <= (full_q & ~(full_wr_in ? ~full_wdata_in : '0)) | full_set;
		end
	end

	// Overflow flags: same write-zero-to-clear behaviour
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ovf_q <= {NBUF{FLAG_RST}};
		end else begin
			ovf_q <= (ovf_q & ~(ovf_wr_in ? ~ovf_wdata_in : '0)) | ovf_set;
		end
	end

	// Flags leave straight from their flops
	assign rx_buffer_full_flag_out     = full_q;
	assign rx_buffer_overflow_flag_out = ovf_q;

endmodule

/* File: tb/cmb_ram_model.sv */
`timescale 1ns/1ps

// Shared DMA memory seen by the engine, with a settable wait
module cmb_ram_model (
	// Clock, reset, wait cycles
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  slow_in,
	// Memory port
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [9:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	output logic             ack_out,
	output logic [15:0]      rdata_out
);
	logic [15:0] mem [1024];
	logic [3:0]  cnt_q;

	// Acknowledge each request after slow_in idle cycles
	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			cnt_q   <= 4'h0;
		end else begin
			ack_out <= 1'b0;
			if (req_in && !ack_out) begin
				if (cnt_q >= slow_in) begin
					ack_out <= 1'b1;
					cnt_q   <= 4'h0;
					if (we_in) begin
						mem[addr_in] <= wdata_in;
					end
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end

	// Read data only valid in the ack cycle, inverted otherwise
	assign rdata_out = ack_out ? mem[addr_in] : ~mem[addr_in];
endmodule

/* File: tb/cmb_msg_buffer_engine_checker.sv */
`timescale 1ns/1ps

// Port-level rules of the buffer engine
module cmb_msg_buffer_engine_checker
	import cmb_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int NBUF   = 32
) (
	input wire logic              clock_in,
	input wire logic              rst_in,
	input wire logic [ADDR_W-1:0] region_base_in,
	input wire logic [5:0]        region_bufs_in,
	input wire logic              rx_valid_in,
	input wire logic              rx_ready_out,
	input wire logic [4:0]        rx_buf_idx_in,
	input wire logic              rx_stored_out,
	input wire logic              rx_dropped_out,
	input wire logic              rx_range_err_out,
	input wire logic              tx_ready_out,
	input wire logic              tx_done_out,
	input wire logic [NBUF-1:0]   rx_buffer_overflow_flag_out,
	input wire logic              ram_req_out,
	input wire logic              ram_we_out,
	input wire logic [ADDR_W-1:0] ram_addr_out,
	input wire logic [WORD_W-1:0] ram_wdata_out,
	input wire logic              ram_ack_in
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	// Word index inside the buffer and write strobe
	logic [2:0] wsel;
	logic       wr;
	assign wsel = ram_addr_out[2:0] - region_base_in[2:0];
	assign wr   = ram_req_out && ram_we_out;

	sequence s_take;
		rx_valid_in && rx_ready_out && rx_buf_idx_in >= region_bufs_in;
	endsequence
	sequence s_reject;
		!ram_req_out [*2] ##0 rx_range_err_out;
	endsequence

	property p_range; s_take |=> s_reject; endproperty
	property p_hold; ram_req_out && !ram_ack_in |=> ram_req_out && $stable(ram_addr_out)
		&& $stable(ram_wdata_out) && $stable(ram_we_out); endproperty
	property p_w0; wr && wsel == 3'h0 |-> ram_wdata_out[15:13] == 3'h0; endproperty
	property p_w1; wr && wsel == 3'h1 |-> ram_wdata_out[15:12] == 4'h0; endproperty
	property p_w2; wr && wsel == 3'h2 |-> ram_wdata_out[8:4] == 5'h00; endproperty
	property p_w7; wr && wsel == 3'h7 |-> ram_wdata_out[15:13] == 3'h0 && ram_wdata_out[7:0] == 8'h00; endproperty
	property p_stored; rx_stored_out |-> $past(ram_ack_in && wr && wsel == 3'h7); endproperty
	property p_drop; rx_dropped_out |-> (|rx_buffer_overflow_flag_out) && !ram_req_out; endproperty
	property p_txdone; tx_done_out |-> $past(ram_ack_in && ram_req_out && !ram_we_out && wsel == 3'h6); endproperty
	property p_busy; ram_req_out |-> !rx_ready_out && !tx_ready_out && ram_addr_out >= region_base_in; endproperty

	a_range: assert property (p_range) else $error("range reject wrong");
	a_hold: assert property (p_hold) else $error("memory request changed early");
	a_w0: assert property (p_w0) else $error("word0 top bits set");
	a_w1: assert property (p_w1) else $error("word1 top bits set");
	a_w2: assert property (p_w2) else $error("word2 reserved bits set");
	a_w7: assert property (p_w7) else $error("word7 unused bits set");
	a_stored: assert property (p_stored) else $error("stored before last word");
	a_drop: assert property (p_drop) else $error("drop without overflow");
	a_txdone: assert property (p_txdone) else $error("fetch done wrongly");
	a_busy: assert property (p_busy) else $error("request while idle or below base");
endmodule

bind cmb_msg_buffer_engine cmb_msg_buffer_engine_checker #(.ADDR_W(ADDR_W), .NBUF(NBUF)) u_chk (
	.clock_in(clock_in), .rst_in(rst_in), .region_base_in(region_base_in), .region_bufs_in(region_bufs_in),
	.rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .rx_buf_idx_in(rx_buf_idx_in),
	.rx_stored_out(rx_stored_out), .rx_dropped_out(rx_dropped_out), .rx_range_err_out(rx_range_err_out),
	.tx_ready_out(tx_ready_out), .tx_done_out(tx_done_out),
	.rx_buffer_overflow_flag_out(rx_buffer_overflow_flag_out), .ram_req_out(ram_req_out),
	.ram_we_out(ram_we_out), .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out), .ram_ack_in(ram_ack_in));

/* File: tb/cmb_msg_buffer_engine_tb.sv */
`timescale 1ns/1ps

module cmb_msg_buffer_engine_tb;
	import cmb_pkg::*;
	// Stimulus
	logic        clock_in = 1'b0, rst_in = 1'b1, rxv = 1'b0, txq = 1'b0, fwr = 1'b0, owr = 1'b0;
	logic        srr = 1'b0, ide = 1'b0, rtr = 1'b0;
	logic [9:0]  rbase = 10'h040;
	logic [5:0]  rbufs = 6'h04;
	logic [4:0]  rxidx = 5'h00, tidx = 5'h00, filt = 5'h00;
	logic [10:0] base_identifier = 11'h000;
	logic [17:0] identifier_extension = 18'h00000;
	logic [3:0]  dlc = 4'h0, slow = 4'h0;
	logic [63:0] pay = 64'h0;
	logic [31:0] fwd = 32'h0, owd = 32'h0;
	// Observed
	logic        rxrdy, st, dr, re, txrdy, tdone, terr, t_srr, t_ide, t_rtr, req, we, ack;
	logic [10:0] t_sid;
	logic [17:0] t_eid;
	logic [3:0]  t_dlc;
	logic [63:0] t_pay;
	logic [31:0] full, ovf;
	logic [9:0]  addr;
	logic [15:0] wd, rd;
	int          error_cnt = 0, num_checks = 0;

	always #4 clock_in = ~clock_in;

	cmb_msg_buffer_engine #(.ADDR_W(10), .NBUF(32)) uut (.clock_in(clock_in), .rst_in(rst_in),
		.region_base_in(rbase), .region_bufs_in(rbufs), .rx_valid_in(rxv), .rx_ready_out(rxrdy),
		.rx_buf_idx_in(rxidx), .rx_base_identifier_in(base_identifier), .rx_srr_in(srr), .rx_ide_in(ide),
		.rx_identifier_extension_in(identifier_extension), .rx_rtr_in(rtr), .rx_dlc_in(dlc), .rx_payload_in(pay),
		.rx_matching_filter_code_in(filt), .rx_stored_out(st), .rx_dropped_out(dr), .rx_range_err_out(re),
		.tx_req_in(txq), .tx_ready_out(txrdy), .tx_buf_idx_in(tidx), .tx_done_out(tdone),
		.tx_range_err_out(terr), .tx_base_identifier_out(t_sid), .tx_srr_out(t_srr), .tx_ide_out(t_ide),
		.tx_identifier_extension_out(t_eid), .tx_rtr_out(t_rtr), .tx_dlc_out(t_dlc), .tx_payload_out(t_pay),
		.full_wr_in(fwr), .full_wdata_in(fwd), .ovf_wr_in(owr), .ovf_wdata_in(owd),
		.rx_buffer_full_flag_out(full), .rx_buffer_overflow_flag_out(ovf), .ram_req_out(req),
		.ram_we_out(we), .ram_addr_out(addr), .ram_wdata_out(wd), .ram_ack_in(ack), .ram_rdata_in(rd));

	cmb_ram_model ram (.clock_in(clock_in), .rst_in(rst_in), .slow_in(slow), .req_in(req), .we_in(we),
		.addr_in(addr), .wdata_in(wd), .ack_out(ack), .rdata_out(rd));

	// Expected buffer word k from the current fields
	function automatic logic [15:0] wexp(input int k);
		case (k)
			0: return {3'h0, base_identifier, srr, ide};
			1: return {4'h0, identifier_extension[17:6]};
			2: return {identifier_extension[5:0], rtr, 1'b0, 3'h0, 1'b0, dlc};
			7: return {3'h0, filt, 8'h00};
			default: return pay[16*(k-3)+:16];
		endcase
	endfunction

	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One receive or fetch; outcome code {range, dropped, stored or done}
	task automatic xfer(input logic is_tx, input logic [4:0] idx, input logic [2:0] ecode);
		int i;
		for (i = 0; i < 100 && rxrdy !== 1'b1; i++) @(negedge clock_in);
		if (i == 100) begin
			error_cnt++;
			give_verdict;
		end else begin
			if (is_tx) begin
				tidx = idx;
				txq = 1'b1;
			end else begin
				rxidx = idx;
				rxv = 1'b1;
			end
			@(negedge clock_in);
			txq = 1'b0;
			rxv = 1'b0;
			for (i = 0; i < 200 && {re | terr, dr, st | tdone} === 3'b000; i++) @(negedge clock_in);
			if (i == 200) begin
				error_cnt++;
				give_verdict;
			end else begin
				chk("outcome", {re | terr, dr, st | tdone}, ecode);
			end
		end
	endtask

	// Flags clear and both sides ready once reset is released
	task automatic t_reset;
		repeat (12) @(negedge clock_in);
		rst_in = 1'b0;
		chk("reset flags", {full, ovf}, 64'h0);
		chk("reset ready", {rxrdy, txrdy}, 2'b11);
		$display("reset test done");
	endtask

	task automatic t_store;
		base_identifier = 11'h5A3; srr = 1'b1; ide = 1'b1; identifier_extension = 18'h2B6C5; rtr = 1'b1; dlc = 4'h8;
		pay = 64'h0123456789ABCDEF; filt = 5'h13; slow = 4'h2;
		xfer(1'b0, 5'h02, 3'b001);
		chk("full", full, 32'h4);
		for (int k = 0; k < 8; k++) chk("word", ram.mem[rbase+16+k], wexp(k));
		pay = ~pay;
		xfer(1'b0, 5'h02, 3'b010);
		chk("ovf", ovf, 32'h4);
		chk("kept word", ram.mem[rbase+19], 16'hCDEF);
		xfer(1'b0, 5'h04, 3'b100);
		xfer(1'b0, 5'h03, 3'b001);
		chk("full2", full, 32'hC);
		$display("receive test done");
	endtask

	task automatic t_clear;
		fwd = ~32'h4;
		owd = 32'h0;
		fwr = 1'b1;
		owr = 1'b1;
		@(negedge clock_in);
		fwr = 1'b0;
		owr = 1'b0;
		chk("full clr", full, 32'h8);
		chk("ovf clr", ovf, 32'h0);
		xfer(1'b0, 5'h02, 3'b001);
		$display("clear test done");
	endtask

	task automatic t_tx;
		base_identifier = 11'h2C1; srr = 1'b0; ide = 1'b0; identifier_extension = 18'h15A3C; rtr = 1'b0; dlc = 4'h3;
		pay = 64'hFEDCBA9876543210; filt = 5'h1F; slow = 4'h3;
		for (int k = 0; k < 8; k++) ram.mem[rbase+8+k] = wexp(k);
		xfer(1'b1, 5'h01, 3'b001);
		chk("tx ctl", {t_sid, t_srr, t_ide, t_eid, t_rtr, t_dlc}, {base_identifier, srr, ide, identifier_extension, rtr, dlc});
		chk("tx pay", t_pay, pay);
		xfer(1'b1, 5'h05, 3'b100);
		$display("fetch test done");
	endtask

	initial begin
		t_reset;
		t_store;
		t_clear;
		t_tx;
		give_verdict;
	end
endmodule
